// File: hdl/ppsl_pkg.sv
// Package of constants and types for the port pin sharing logic
package ppsl_pkg;
  localparam int PORT_W = 8;                   // Width of each common port
  localparam int OD_BITS = 4;                  // Port A bits with open-drain option
  localparam int PWM_CH = 4;                   // Pulse width outputs on port D
  // Port A shared bit positions
  localparam int PA_BUZ = 0;
  localparam int PA_BUZN = 1;
  localparam int PA_PFD = 3;
  localparam int PA_T2 = 4;
  localparam int PA_T3 = 5;
  // Port D shared bit positions
  localparam int PD_IRQ0 = 4;
  localparam int PD_IRQ1 = 5;
  localparam int PD_T0 = 6;
  localparam int PD_T1 = 7;
  // Reset values
  localparam logic [7:0] DATA_RST = 8'hFF;     // Data latches reset high
  localparam logic [7:0] DIR_RST = 8'hFF;      // All pins inputs after reset
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam logic [1:0] DIV_RST = 2'h0;
  // System clock source options
  typedef enum logic [1:0] {
    PPSL_OSC_XTAL,
    PPSL_OSC_RC,
    PPSL_OSC_EXT
  } ppsl_osc_t;
endpackage

// File: hdl/ppsl_sync.sv
// Two flip-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
`default_nettype none
module ppsl_sync #(
  parameter int W = 8
) (
  input  wire logic         clk,     // System clock
  input  wire logic         rst,     // Asynchronous reset, active high
  input  wire logic [W-1:0] async_i, // Raw pin levels
  output logic      [W-1:0] sync_o   // Synchronised levels
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // First stage read only by the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;
endmodule
`default_nettype wire

// File: hdl/ppsl_port.sv
// One 8-bit bidirectional port: data and direction latches, pin drive
`timescale 1ns/1ps
`default_nettype none
module ppsl_port (
  input  wire logic                          clk,        // System clock
  input  wire logic                          rst,        // Asynchronous reset
  input  wire logic                          data_wr,    // Data latch write strobe
  input  wire logic [ppsl_pkg::PORT_W-1:0]   data_wdata, // Data latch write value
  input  wire logic                          dir_wr,     // Direction write strobe
  input  wire logic [ppsl_pkg::PORT_W-1:0]   dir_wdata,  // 1 = input, 0 = output
  input  wire logic [ppsl_pkg::PORT_W-1:0]   pullup_en,  // Pull-high request
  input  wire logic [ppsl_pkg::PORT_W-1:0]   fn_sel,     // Shared output owns pin
  input  wire logic [ppsl_pkg::PORT_W-1:0]   fn_val,     // Shared output value
  input  wire logic [ppsl_pkg::PORT_W-1:0]   od_sel,     // Open-drain select
  input  wire logic [ppsl_pkg::PORT_W-1:0]   analog_sel, // Pin given to analog path
  output logic      [ppsl_pkg::PORT_W-1:0]   pin_o,      // Pin output level
  output logic      [ppsl_pkg::PORT_W-1:0]   pin_oe_n,   // Low while driving
  output logic      [ppsl_pkg::PORT_W-1:0]   pin_pu,     // Pull-up connect
  output logic      [ppsl_pkg::PORT_W-1:0]   data_q_o,   // Data latch
  output logic      [ppsl_pkg::PORT_W-1:0]   dir_q_o     // Direction latch
);
  logic [ppsl_pkg::PORT_W-1:0] data_q;
  logic [ppsl_pkg::PORT_W-1:0] dir_q;
  logic [ppsl_pkg::PORT_W-1:0] drv_d;
  logic [ppsl_pkg::PORT_W-1:0] oe_n_d;
  logic [ppsl_pkg::PORT_W-1:0] pu_d;
  logic [ppsl_pkg::PORT_W-1:0] pin_q;
  logic [ppsl_pkg::PORT_W-1:0] oe_n_q;
  logic [ppsl_pkg::PORT_W-1:0] pu_q;

  // Data and direction latches
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_q <= ppsl_pkg::DATA_RST;
      dir_q  <= ppsl_pkg::DIR_RST;
    end else begin
      if (data_wr) data_q <= data_wdata;
      if (dir_wr) dir_q <= dir_wdata;
    end
  end

  // Per-pin drive selection
  genvar i;
  generate
    for (i = 0; i < ppsl_pkg::PORT_W; i++) begin : g_pin
      // Peripheral value replaces latch when it owns the pin
      assign drv_d[i] = fn_sel[i] ? fn_val[i] : data_q[i];
      // Push-pull output or Schmitt input; open drain only pulls low
      assign oe_n_d[i] = analog_sel[i] | (dir_q[i] & ~fn_sel[i])
                         | (od_sel[i] & drv_d[i]);
      assign pu_d[i] = pullup_en[i] & ~analog_sel[i];
    end
  endgenerate

  // Registered pin drive
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_q  <= ppsl_pkg::ZERO8;
      oe_n_q <= ppsl_pkg::DIR_RST;
      pu_q   <= ppsl_pkg::ZERO8;
    end else begin
      pin_q  <= drv_d;
      oe_n_q <= oe_n_d;
      pu_q   <= pu_d;
    end
  end

  assign pin_o    = pin_q;
  assign pin_oe_n = oe_n_q;
  assign pin_pu   = pu_q;
  assign data_q_o = data_q;
  assign dir_q_o  = dir_q;
endmodule
`default_nettype wire

// File: hdl/ppsl_top.sv
// Pin sharing logic for ports A, B, D and the oscillator pins
//--------------------------------------------------------------------
// What this block does
// - Ports A, B and D are each eight bits wide and every bit is bidirectional.
// - Software makes each pin a push-pull output or a Schmitt-trigger input.
// - Every pin of ports A, B and D has its own pull-high enable bit.
// - Each port A bit can be enabled as a wake-up source ending power-down.
// - Port A bits 0,1,3,4,5 carry buzzer, inverted buzzer, divider, timer 2 and 3 by option.
// - Port A bits 0 to 3 can be switched to open-drain output.
// - Port B pins selected as analog inputs lose their digital path and pull-high.
// - Port D bits 0 to 3 are taken by the PWM outputs when the PWM controls say so.
// - Port D bits 4 to 7 feed external interrupts 0, 1 and timer 0, 1 inputs.
// - The clock source is crystal, RC or external clock by option, external into the input pin.
// - In RC mode the oscillator output pin shows the system clock divided by four.
//--------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module ppsl_top (
  input  wire logic       clk,                   // System clock
  input  wire logic       rst,                   // Asynchronous reset, active high

  // Option bits
  input  wire logic       opt_buzzer_en,         // Buzzer pair on PA0/PA1
  input  wire logic       opt_freq_div_en,       // Divider output on PA3
  input  wire logic       opt_timer2_en,         // Timer 2 input on PA4
  input  wire logic       opt_timer3_en,         // Timer 3 input on PA5
  input  wire logic [1:0] opt_osc_mode,          // Clock source option

  // Software control, port A
  input  wire logic       pa_data_wr,            // Port A latch write
  input  wire logic       pa_dir_wr,             // Port A direction write
  input  wire logic [7:0] pa_wdata,              // Port A write value
  input  wire logic [7:0] port_a_pullup_enable,  // Port A pull-high enables
  input  wire logic [7:0] port_a_wake_enable,    // Port A wake-up enables
  input  wire logic [3:0] port_a_open_drain,     // PA0..PA3 open-drain select

  // Software control, port B
  input  wire logic       pb_data_wr,            // Port B latch write
  input  wire logic       pb_dir_wr,             // Port B direction write
  input  wire logic [7:0] pb_wdata,              // Port B write value
  input  wire logic [7:0] port_b_pullup_enable,  // Port B pull-high enables
  input  wire logic [7:0] port_b_analog_sel,     // Port B analog select

  // Software control, port D
  input  wire logic       pd_data_wr,            // Port D latch write
  input  wire logic       pd_dir_wr,             // Port D direction write
  input  wire logic [7:0] pd_wdata,              // Port D write value
  input  wire logic [7:0] port_d_pullup_enable,  // Port D pull-high enables
  input  wire logic [3:0] pwm_pin_sel,           // PWM channel owns PD pin

  // Peripheral outputs
  input  wire logic       buzzer_out,            // Buzzer signal
  input  wire logic       freq_divider_out,      // Divider signal
  input  wire logic [3:0] pulse_width_out_0_to_3,// PWM channels
  input  wire logic       sys_clk_div_src,       // Unused marker tied by user

  // Pins
  input  wire logic [7:0] pa_pin_i,              // Port A pin levels
  output logic      [7:0] pa_pin_o,              // Port A drive level
  output logic      [7:0] pa_pin_oe_n,           // Port A enable, low drives
  output logic      [7:0] pa_pin_pu,             // Port A pull-up connect
  input  wire logic [7:0] pb_pin_i,              // Port B pin levels
  output logic      [7:0] pb_pin_o,              // Port B drive level
  output logic      [7:0] pb_pin_oe_n,           // Port B enable, low drives
  output logic      [7:0] pb_pin_pu,             // Port B pull-up connect
  output logic      [7:0] analog_in_0_to_7,      // Analog switch close per channel
  input  wire logic [7:0] pd_pin_i,              // Port D pin levels
  output logic      [7:0] pd_pin_o,              // Port D drive level
  output logic      [7:0] pd_pin_oe_n,           // Port D enable, low drives
  output logic      [7:0] pd_pin_pu,             // Port D pull-up connect
  input  wire logic       osc_input_pin,         // Oscillator input pin level
  output logic            osc_output_pin,        // Oscillator output pin
  output logic            osc_output_oe_n,       // Low while driving output pin
  output logic            external_clock_mode,   // External clock selected
  output logic            xtal_amp_en,           // Crystal amplifier enable

  // Read-back and peripheral inputs
  output logic      [7:0] pa_read,               // Port A read value
  output logic      [7:0] pb_read,               // Port B read value
  output logic      [7:0] pd_read,               // Port D read value
  output logic            wake_up,               // Wake-up request
  output logic            timer0_ext_input,      // Timer 0 input
  output logic            timer1_ext_input,      // Timer 1 input
  output logic            timer2_ext_input,      // Timer 2 input
  output logic            timer3_ext_input,      // Timer 3 input
  output logic            ext_irq0_input,        // External interrupt 0
  output logic            ext_irq1_input         // External interrupt 1
);
  //------------------------------------------------------------------
  // Pin synchronisers
  //------------------------------------------------------------------
  logic [7:0] pa_s;
  logic [7:0] pb_s;
  logic [7:0] pd_s;

  logic [7:0] pa_data;
  logic [7:0] pa_dir;
  logic [7:0] pb_data;
  logic [7:0] pb_dir;
  logic [7:0] pd_data;
  logic [7:0] pd_dir;

  ppsl_sync #(.W(24)) u_sync (
    .clk     (clk),
    .rst     (rst),
    .async_i ({pd_pin_i, pb_pin_i, pa_pin_i}),
    .sync_o  ({pd_s, pb_s, pa_s})
  );

  //------------------------------------------------------------------
  // Shared function selection
  //------------------------------------------------------------------
  logic [7:0] pa_fn_sel;
  logic [7:0] pa_fn_val;
  logic [7:0] pa_od;

  logic [7:0] pd_fn_sel;
  logic [7:0] pd_fn_val;

  // Port A option-chosen outputs
  assign pa_fn_sel = {4'h0, opt_freq_div_en, 1'b0, opt_buzzer_en, opt_buzzer_en};
  assign pa_fn_val = {4'h0, freq_divider_out, 1'b0, ~buzzer_out, buzzer_out};
  assign pa_od     = {4'h0, port_a_open_drain};

  // Port D PWM takeover
  assign pd_fn_sel = {4'h0, pwm_pin_sel};
  assign pd_fn_val = {4'h0, pulse_width_out_0_to_3};

  //------------------------------------------------------------------
  // Ports
  //------------------------------------------------------------------
  // Three identical bidirectional ports
  ppsl_port u_pa (
    .clk        (clk),
    .rst        (rst),
    .data_wr    (pa_data_wr),
    .data_wdata (pa_wdata),
    .dir_wr     (pa_dir_wr),
    .dir_wdata  (pa_wdata),
    .pullup_en  (port_a_pullup_enable),
    .fn_sel     (pa_fn_sel),
    .fn_val     (pa_fn_val),
    .od_sel     (pa_od),
    .analog_sel (ppsl_pkg::ZERO8),
    .pin_o      (pa_pin_o),
    .pin_oe_n   (pa_pin_oe_n),
    .pin_pu     (pa_pin_pu),
    .data_q_o   (pa_data),
    .dir_q_o    (pa_dir)
  );

  ppsl_port u_pb (
    .clk        (clk),
    .rst        (rst),
    .data_wr    (pb_data_wr),
    .data_wdata (pb_wdata),
    .dir_wr     (pb_dir_wr),
    .dir_wdata  (pb_wdata),
    .pullup_en  (port_b_pullup_enable),
    .fn_sel     (ppsl_pkg::ZERO8),
    .fn_val     (ppsl_pkg::ZERO8),
    .od_sel     (ppsl_pkg::ZERO8),
    .analog_sel (port_b_analog_sel),
    .pin_o      (pb_pin_o),
    .pin_oe_n   (pb_pin_oe_n),
    .pin_pu     (pb_pin_pu),
    .data_q_o   (pb_data),
    .dir_q_o    (pb_dir)
  );

  ppsl_port u_pd (
    .clk        (clk),
    .rst        (rst),
    .data_wr    (pd_data_wr),
    .data_wdata (pd_wdata),
    .dir_wr     (pd_dir_wr),
    .dir_wdata  (pd_wdata),
    .pullup_en  (port_d_pullup_enable),
    .fn_sel     (pd_fn_sel),
    .fn_val     (pd_fn_val),
    .od_sel     (ppsl_pkg::ZERO8),
    .analog_sel (ppsl_pkg::ZERO8),
    .pin_o      (pd_pin_o),
    .pin_oe_n   (pd_pin_oe_n),
    .pin_pu     (pd_pin_pu),
    .data_q_o   (pd_data),
    .dir_q_o    (pd_dir)
  );

  //------------------------------------------------------------------
  // Read-back, wake-up and peripheral inputs
  //------------------------------------------------------------------
  logic [7:0] pa_rd_d;
  logic [7:0] pb_rd_d;
  logic [7:0] pd_rd_d;
  logic       wake_d;

  logic       pa_wake_ref_q;
  logic [7:0] pa_prev_q;
  logic [7:0] pa_rd_q;
  logic [7:0] pb_rd_q;
  logic [7:0] pd_rd_q;
  logic       wake_q;
  logic [5:0] in_q;

  // Inputs read the pin, outputs read the latch; analog bits read zero
  assign pa_rd_d = (pa_dir & pa_s) | (~pa_dir & pa_data);
  assign pb_rd_d = ((pb_dir & pb_s) | (~pb_dir & pb_data)) & ~port_b_analog_sel;
  assign pd_rd_d = (pd_dir & pd_s) | (~pd_dir & pd_data);
  // Any change on an enabled port A pin asks for wake-up
  assign wake_d = |((pa_s ^ pa_prev_q) & port_a_wake_enable & {8{pa_wake_ref_q}});

  // Registered read-back and input routing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pa_prev_q     <= ppsl_pkg::ZERO8;
      pa_wake_ref_q <= 1'b0;
      pa_rd_q       <= ppsl_pkg::ZERO8;
      pb_rd_q       <= ppsl_pkg::ZERO8;
      pd_rd_q       <= ppsl_pkg::ZERO8;
      wake_q        <= 1'b0;
      in_q          <= 6'h00;
    end else begin
      pa_prev_q     <= pa_s;
      pa_wake_ref_q <= 1'b1;
      pa_rd_q       <= pa_rd_d;
      pb_rd_q       <= pb_rd_d;
      pd_rd_q       <= pd_rd_d;
      wake_q        <= wake_d;
      in_q[0]       <= pd_s[ppsl_pkg::PD_T0];
      in_q[1]       <= pd_s[ppsl_pkg::PD_T1];
      in_q[2]       <= pd_s[ppsl_pkg::PD_IRQ0];
      in_q[3]       <= pd_s[ppsl_pkg::PD_IRQ1];
      in_q[4]       <= opt_timer2_en & pa_s[ppsl_pkg::PA_T2];
      in_q[5]       <= opt_timer3_en & pa_s[ppsl_pkg::PA_T3];
    end
  end

  assign pa_read          = pa_rd_q;
  assign pb_read          = pb_rd_q;
  assign pd_read          = pd_rd_q;
  assign wake_up          = wake_q;
  assign timer0_ext_input = in_q[0];
  assign timer1_ext_input = in_q[1];
  assign ext_irq0_input   = in_q[2];
  assign ext_irq1_input   = in_q[3];
  assign timer2_ext_input = in_q[4];
  assign timer3_ext_input = in_q[5];

  //------------------------------------------------------------------
  // Analog switches
  //------------------------------------------------------------------
  logic [7:0] an_q;

  // Close the analog switch of each selected port B pin
  always_ff @(posedge clk or posedge rst) begin
    if (rst) an_q <= ppsl_pkg::ZERO8;
    else an_q <= port_b_analog_sel;
  end

  assign analog_in_0_to_7 = an_q;

  //------------------------------------------------------------------
  // Oscillator pins
  //------------------------------------------------------------------
  logic       rc_mode;
  logic       ext_mode;

  logic [1:0] div_q;
  logic       osc_o_q;
  logic       osc_oe_n_q;
  logic       ext_q;
  logic       xtal_q;

  assign rc_mode  = opt_osc_mode == ppsl_pkg::PPSL_OSC_RC;
  assign ext_mode = opt_osc_mode == ppsl_pkg::PPSL_OSC_EXT;

  // Divide the system clock by four for the output pin in RC mode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_q      <= ppsl_pkg::DIV_RST;
      osc_o_q    <= 1'b0;
      osc_oe_n_q <= 1'b1;
      ext_q      <= 1'b0;
      xtal_q     <= 1'b0;
    end else begin
      div_q      <= div_q + 2'h1;
      osc_o_q    <= rc_mode & div_q[1];
      osc_oe_n_q <= ~rc_mode;
      ext_q      <= ext_mode;
      xtal_q     <= ~rc_mode & ~ext_mode;
    end
  end

  assign osc_output_pin      = osc_o_q;
  assign osc_output_oe_n     = osc_oe_n_q;
  assign external_clock_mode = ext_q;
  assign xtal_amp_en         = xtal_q;
endmodule
`default_nettype wire

// File: sim/ppsl_top_properties.sv
// Concurrent checks on the pin sharing ports
`timescale 1ns/1ps
`default_nettype none
module ppsl_top_properties (
  input wire logic       clk,                    // Clock
  input wire logic       rst,                    // Reset
  input wire logic       opt_buzzer_en,          // Buzzer option
  input wire logic       opt_freq_div_en,        // Divider option
  input wire logic [1:0] opt_osc_mode,           // Clock source
  input wire logic [3:0] port_a_open_drain,      // Open-drain selects
  input wire logic [7:0] port_a_wake_enable,     // Wake enables
  input wire logic [7:0] port_b_analog_sel,      // Analog selects
  input wire logic [3:0] pwm_pin_sel,            // PWM owners
  input wire logic       buzzer_out,             // Buzzer
  input wire logic       freq_divider_out,       // Divider
  input wire logic [3:0] pulse_width_out_0_to_3, // PWM levels
  input wire logic [7:0] pd_pin_i,               // Port D pins
  input wire logic [7:0] pa_pin_o,               // Port A drive
  input wire logic [7:0] pa_pin_oe_n,            // Port A enable
  input wire logic [7:0] pb_pin_oe_n,            // Port B enable
  input wire logic [7:0] pb_pin_pu,              // Port B pull-up
  input wire logic [7:0] pd_pin_o,               // Port D drive
  input wire logic [7:0] pd_pin_oe_n,            // Port D enable
  input wire logic       osc_output_pin,         // Oscillator out
  input wire logic       osc_output_oe_n,        // Oscillator enable
  input wire logic       external_clock_mode,    // External clock
  input wire logic       xtal_amp_en,            // Crystal amp
  input wire logic       wake_up,                // Wake request
  input wire logic       timer0_ext_input,       // Timer 0 in
  input wire logic       timer1_ext_input,       // Timer 1 in
  input wire logic       ext_irq0_input,         // Interrupt 0
  input wire logic       ext_irq1_input          // Interrupt 1
);
  //----------------------------------------------------------
  // Pin sharing properties
  //----------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Port D pins held long enough to cross the synchroniser
  sequence pd_quiet_s;
    (!rst && $stable(pd_pin_i)) [*6];
  endsequence
  // RC clock option held for several cycles
  sequence rc_run_s;
    (!rst && opt_osc_mode == 2'h1) [*6];
  endsequence
  analog_float_a:
    assert property (!$past(rst) |-> &(pb_pin_oe_n | ~$past(port_b_analog_sel)))
    else $error("analog pin driven");
  analog_pull_a:
    assert property (!$past(rst) |-> (pb_pin_pu & $past(port_b_analog_sel)) == 8'h00)
    else $error("analog pin pulled up");
  pwm_take_a:
    assert property (!$past(rst) |-> (pd_pin_oe_n[3:0] & $past(pwm_pin_sel)) == 4'h0 &&
      ((pd_pin_o[3:0] ^ $past(pulse_width_out_0_to_3)) & $past(pwm_pin_sel)) == 4'h0)
    else $error("pwm pin not driven by channel");
  buzzer_pair_a:
    assert property (!$past(rst) && $past(opt_buzzer_en) && $past(port_a_open_drain[1:0]) == 2'h0
      |-> pa_pin_oe_n[1:0] == 2'h0 && pa_pin_o[1:0] == {!$past(buzzer_out), $past(buzzer_out)})
    else $error("buzzer pair wrong");
  divider_pin_a:
    assert property (!$past(rst) && $past(opt_freq_div_en) && !$past(port_a_open_drain[3])
      |-> !pa_pin_oe_n[3] && pa_pin_o[3] == $past(freq_divider_out))
    else $error("divider pin wrong");
  rc_quarter_a:
    assert property (rc_run_s |-> osc_output_pin != $past(osc_output_pin, 2) && !osc_output_oe_n)
    else $error("rc monitor not quarter rate");
  clock_source_a:
    assert property (!$past(rst) |-> external_clock_mode == ($past(opt_osc_mode) == 2'h2) &&
      xtal_amp_en == ($past(opt_osc_mode) inside {2'h0, 2'h3}))
    else $error("clock source flags wrong");
  irq_route_a:
    assert property (pd_quiet_s |-> {timer1_ext_input, timer0_ext_input, ext_irq1_input,
      ext_irq0_input} == pd_pin_i[7:4])
    else $error("port D inputs misrouted");
  wake_quiet_a:
    assert property ((!rst && port_a_wake_enable == 8'h00) [*6] |-> !wake_up)
    else $error("wake without enable");
endmodule
`default_nettype wire

// File: sim/tb_top.sv
// Self-checking testbench for the pin sharing logic
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  //----------------------------------------------------------
  // Signals
  //----------------------------------------------------------
  logic        clk, rst, opt_buzzer_en, opt_freq_div_en, opt_timer2_en, opt_timer3_en;
  logic [1:0]  opt_osc_mode;
  logic        pa_data_wr, pa_dir_wr, pb_data_wr, pb_dir_wr, pd_data_wr, pd_dir_wr;
  logic [7:0]  pa_wdata, pb_wdata, pd_wdata, pa_pin_i, pb_pin_i, pd_pin_i;
  logic [7:0]  port_a_pullup_enable, port_b_pullup_enable, port_d_pullup_enable;
  logic [7:0]  port_a_wake_enable, port_b_analog_sel;
  logic [3:0]  port_a_open_drain, pwm_pin_sel, pulse_width_out_0_to_3;
  logic        buzzer_out, freq_divider_out, osc_input_pin, sys_clk_div_src;
  logic [7:0]  pa_pin_o, pa_pin_oe_n, pa_pin_pu, pb_pin_o, pb_pin_oe_n, pb_pin_pu;
  logic [7:0]  pd_pin_o, pd_pin_oe_n, pd_pin_pu, analog_in_0_to_7, pa_read, pb_read, pd_read;
  logic        osc_output_pin, osc_output_oe_n, external_clock_mode, xtal_amp_en, wake_up;
  logic        timer0_ext_input, timer1_ext_input, timer2_ext_input, timer3_ext_input;
  logic        ext_irq0_input, ext_irq1_input;
  logic [31:0] seed, r1, r2, r3, r4, r5;
  logic [7:0]  sha, shd, eoa, eob, eod, eva, n;
  int          bad_count, n_compared;

  ppsl_top i_ppsl_top (.*);

  // Clock at 25 MHz
  always #20 clk = ~clk;

  //----------------------------------------------------------
  // Helpers
  //----------------------------------------------------------
  // Xorshift step for repeatable stimulus
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Read-back: input bits show the pin, output bits the latch
  function automatic logic [7:0] rd_exp(input logic [7:0] pin, dat, dir);
    return (pin & dir) | (dat & ~dir);
  endfunction
  // Masked compare of an 8-bit result
  task automatic cmp(input logic [7:0] got, exp, msk);
    n_compared++;
    if ((got & msk) !== (exp & msk)) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got & msk, exp & msk);
    end
  endtask
  // One write cycle to all three ports, latch or direction
  task automatic wr(input logic [7:0] a, b, d, input logic dir);
    @(posedge clk);
    {pa_data_wr, pb_data_wr, pd_data_wr} <= {3{!dir}};
    {pa_dir_wr, pb_dir_wr, pd_dir_wr} <= {3{dir}};
    pa_wdata <= a;
    pb_wdata <= b;
    pd_wdata <= d;
  endtask
  // Counts wake pulses over ten cycles
  task automatic pulses(output logic [7:0] c);
    c = 8'h00;
    repeat (10) begin
      @(negedge clk);
      c = c + {7'h0, wake_up};
    end
  endtask
  task automatic end_sim();
    $display("compared=%0d bad=%0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  //----------------------------------------------------------
  // Tests
  //----------------------------------------------------------
  // Watchdog well beyond the expected run
  initial begin
    #400000;
    bad_count++;
    end_sim();
  end
  // Main sequence
  initial begin
    clk = 1'h0;
    rst = 1'h1;
    seed = 32'h0000FC87;
    bad_count = 0;
    n_compared = 0;
    {opt_buzzer_en, opt_freq_div_en, opt_timer2_en, opt_timer3_en, opt_osc_mode} = 6'h00;
    {pa_data_wr, pa_dir_wr, pb_data_wr, pb_dir_wr, pd_data_wr, pd_dir_wr} = 6'h00;
    {pa_wdata, pb_wdata, pd_wdata, pa_pin_i, pb_pin_i, pd_pin_i} = 48'h0;
    {port_a_pullup_enable, port_b_pullup_enable, port_d_pullup_enable} = 24'h0;
    {port_a_wake_enable, port_b_analog_sel} = 16'h0;
    {port_a_open_drain, pwm_pin_sel, pulse_width_out_0_to_3} = 12'h0;
    {buzzer_out, freq_divider_out, osc_input_pin, sys_clk_div_src} = 4'h0;
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    cmp(pa_pin_oe_n & pb_pin_oe_n & pd_pin_oe_n, 8'hFF, 8'hFF);
    $display("test reset done");
    // Random port traffic with corner cases first
    for (int i = 0; i < 40; i++) begin
      r1 = rnd();
      r2 = rnd();
      r3 = rnd();
      r4 = rnd();
      r5 = rnd();
      if (i == 0) begin
        r1 = 32'hFFFFFFFF;
        r2 = 32'h0;
        r5 = 32'h0;
      end
      if (i == 1) begin
        r2 = 32'hFFFFFFFF;
        r4[7:0] = 8'hFF;
      end
      wr(r1[7:0], r1[15:8], r1[23:16], 1'h0);
      wr(r2[7:0], r2[15:8], r2[23:16], 1'h1);
      @(posedge clk);
      {pa_data_wr, pb_data_wr, pd_data_wr, pa_dir_wr, pb_dir_wr, pd_dir_wr} <= 6'h00;
      {port_d_pullup_enable, port_b_pullup_enable, port_a_pullup_enable} <= r3[23:0];
      {pd_pin_i, pb_pin_i, pa_pin_i, port_b_analog_sel} <= r4;
      port_a_open_drain <= r1[27:24] & ~{r5[1], 1'h0, r5[0], r5[0]};
      pwm_pin_sel <= r2[27:24];
      {pulse_width_out_0_to_3, freq_divider_out, buzzer_out} <= r5[9:4];
      {opt_timer3_en, opt_timer2_en, opt_freq_div_en, opt_buzzer_en} <= r5[3:0];
      repeat (8) @(posedge clk);
      @(negedge clk);
      sha = {4'h0, r5[1], 1'h0, r5[0], r5[0]};
      shd = {4'h0, r2[27:24]};
      eoa = (r2[7:0] | {4'h0, port_a_open_drain & r1[3:0]}) & ~sha;
      eva = (r1[7:0] & ~sha) | ({4'h0, r5[5], 1'h0, ~r5[4], r5[4]} & sha);
      eob = r2[15:8] | r4[7:0];
      eod = r2[23:16] & ~shd;
      cmp(pa_pin_oe_n, eoa, 8'hFF);
      cmp(pa_pin_o, eva, ~eoa);
      cmp(pa_pin_pu, r3[7:0], r2[7:0] & ~sha);
      cmp(pa_read, rd_exp(r4[15:8], r1[7:0], r2[7:0]), ~sha);
      cmp(pb_pin_oe_n, eob, 8'hFF);
      cmp(pb_pin_o, r1[15:8], ~eob);
      cmp(pb_pin_pu, r3[15:8] & ~r4[7:0], eob);
      cmp(pb_read, rd_exp(r4[23:16], r1[15:8], r2[15:8]) & ~r4[7:0], 8'hFF);
      cmp(analog_in_0_to_7, r4[7:0], 8'hFF);
      cmp(pd_pin_oe_n, eod, 8'hFF);
      cmp(pd_pin_o, (r1[23:16] & ~shd) | {4'h0, r5[9:6] & r2[27:24]}, ~eod);
      cmp(pd_pin_pu, r3[23:16], eod);
      cmp(pd_read, rd_exp(r4[31:24], r1[23:16], r2[23:16]), ~shd);
      cmp({4'h0, timer1_ext_input, timer0_ext_input, ext_irq1_input, ext_irq0_input},
          {4'h0, r4[31:28]}, 8'hFF);
      cmp({6'h0, timer3_ext_input, timer2_ext_input},
          {6'h0, r5[3] & r4[13], r5[2] & r4[12]}, 8'hFF);
    end
    $display("test ports done");
    // Wake-up on each port A bit, and none from a masked bit
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      port_a_wake_enable <= 8'h01 << k;
      repeat (8) @(posedge clk);
      pa_pin_i <= pa_pin_i ^ (8'h01 << k);
      pulses(n);
      cmp(n, 8'h01, 8'hFF);
      @(posedge clk);
      pa_pin_i <= pa_pin_i ^ (8'h01 << ((k + 1) % 8));
      pulses(n);
      cmp(n, 8'h00, 8'hFF);
    end
    $display("test wake done");
    // Every clock source option, quarter rate monitor in RC mode
    for (int md = 0; md < 4; md++) begin
      @(posedge clk);
      opt_osc_mode <= md[1:0];
      repeat (8) @(posedge clk);
      @(negedge clk);
      cmp({6'h0, external_clock_mode, xtal_amp_en}, {6'h0, md == 2, md % 3 == 0}, 8'hFF);
      pulses(n);
      n = 8'h00;
      repeat (8) begin
        @(negedge clk);
        n = n + {7'h0, osc_output_pin};
      end
      cmp(n, (md == 1) ? 8'h04 : 8'h00, 8'hFF);
      cmp({7'h0, osc_output_oe_n}, {7'h0, md != 1}, 8'hFF);
    end
    $display("test osc done");
    end_sim();
  end
endmodule

bind ppsl_top ppsl_top_properties i_ppsl_top_properties (.*);
`default_nettype wire
